// [core/lcdrv_dev.sv]
// Display driver end: pin and command reset, power control and contrast volume registers
`timescale 1ns/10ps
// Contract
// - Five-bit volume register, set by its command.
// - Host enables regulator and follower before volume.
// - Host preloads mid-scale volume before tuning.
// - Unused volume is kept at zero.
// - Host enters standby before powering off.
// - Pin reset: display off, normal, order low, no RMW.
// - Pin reset clears power control to 000.
// - Pin reset clears serial input register.
// - Reset sets default bias ratio per variant.
// - Reset: static indicator off, start line 1.
// - Reset: column counter 0, page 0.
// - Reset: output status D3, volume zero, test off.
// - Soft reset applies only items 10 to 12.
// - Pin reset spares oscillator and timing outputs.
// - Host holds reset during external supply power-on.
// - Host always pin-resets at power-up.
// - Power bits: D2 booster, D1 regulator, D0 follower.
// - During reset, status shows reset and busy.
module lcdrv_dev #(
  parameter bit LARGE_VARIANT = 1'b0
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  lcdrv_if.dev link,
  output logic display_on,
  output logic invert,
  output logic order_rev,
  output logic rmw_on,
  output logic booster_en,
  output logic regulator_en,
  output logic follower_en,
  output logic bias_sel,
  output logic static_on,
  output logic [5:0] start_line,
  output logic [7:0] column,
  output logic [3:0] page,
  output logic out_stat_d3,
  output logic [4:0] volume,
  output logic test_on,
  output logic [7:0] ser_word,
  output logic ser_word_valid,
  output logic frame_alternation,
  output logic display_clock_out,
  output logic common_start_pulse
);
  typedef enum logic [1:0] {
    LCDRV_ST_IDLE = 2'b00,
    LCDRV_ST_PIN = 2'b01,
    LCDRV_ST_BUSY = 2'b10
  } lcdrv_state_t;

  function automatic logic sync_stable(input logic a, input logic b);
    sync_stable = (a == b);
  endfunction : sync_stable

  // Three-stage synchronisers for the pin inputs; stage 1 only feeds stage 2
  logic [2:0] rst_sync_r;
  logic [2:0] sclk_sync_r;
  logic [2:0] sdat_sync_r;
  logic rst_lvl_r;
  logic sclk_lvl_r;
  logic sclk_prev_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // Starts as pin asserted, matching rst_lvl_r, so no false release follows sys_rst
      rst_sync_r <= 3'h7;
      sclk_sync_r <= 3'h0;
      sdat_sync_r <= 3'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[1:0], ~link.init_pin_n};
      sclk_sync_r <= {sclk_sync_r[1:0], link.ser_clk};
      sdat_sync_r <= {sdat_sync_r[1:0], link.ser_data};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rst_lvl_r <= 1'b1;
      sclk_lvl_r <= 1'b0;
      sclk_prev_r <= 1'b0;
    end else begin
      if (sync_stable(rst_sync_r[1], rst_sync_r[2])) begin
        rst_lvl_r <= rst_sync_r[2];
      end
      if (sync_stable(sclk_sync_r[1], sclk_sync_r[2])) begin
        sclk_lvl_r <= sclk_sync_r[2];
      end
      sclk_prev_r <= sclk_lvl_r;
    end
  end

  // The pin is sampled rather than acted on asynchronously so that a glitch cannot tear registers;
  // the registers other than the timing outputs are held at their reset values for every cycle the filtered level rst_lvl_r stays high.
  wire pin_rst = sys_rst | rst_lvl_r;
  wire sclk_rise = sclk_lvl_r & ~sclk_prev_r;

  lcdrv_state_t state_r;
  logic [lcdrv_pkg::BUSY_CNT_W-1:0] busy_cnt_r;
  wire cmd_take = link.cmd_valid & (state_r == LCDRV_ST_IDLE);
  wire soft_rst = cmd_take & (link.cmd_code == lcdrv_pkg::CMD_SOFT_RST);

  always_ff @(posedge ref_clk) begin
    if (pin_rst) begin
      state_r <= LCDRV_ST_PIN;
      busy_cnt_r <= '0;
    end else begin
      case (state_r)
        LCDRV_ST_IDLE: begin
          if (soft_rst) begin
            state_r <= LCDRV_ST_BUSY;
            busy_cnt_r <= '0;
          end
        end
        LCDRV_ST_PIN, LCDRV_ST_BUSY: begin
          if (busy_cnt_r == lcdrv_pkg::BUSY_CNT_W'(lcdrv_pkg::INIT_BUSY_CYC - 1)) begin
            state_r <= LCDRV_ST_IDLE;
            busy_cnt_r <= '0;
          end else begin
            busy_cnt_r <= busy_cnt_r + 1'b1;
          end
        end
        default: state_r <= LCDRV_ST_PIN;
      endcase
    end
  end

  wire wr_ok = cmd_take & ~soft_rst;
  function automatic logic is_cmd(input logic [3:0] code, input logic [3:0] want);
    is_cmd = (code == want);
  endfunction : is_cmd

  // Items cleared only by the pin
  always_ff @(posedge ref_clk) begin
    if (pin_rst) begin
      display_on <= 1'b0;
      invert <= 1'b0;
      order_rev <= 1'b0;
      rmw_on <= 1'b0;
      bias_sel <= LARGE_VARIANT ? lcdrv_pkg::BIAS_RST_LARGE : lcdrv_pkg::BIAS_RST_SMALL;
    end else if (wr_ok) begin
      if (is_cmd(link.cmd_code, lcdrv_pkg::CMD_DISP)) display_on <= link.cmd_data[0];
      if (is_cmd(link.cmd_code, lcdrv_pkg::CMD_INVERT)) invert <= link.cmd_data[0];
      if (is_cmd(link.cmd_code, lcdrv_pkg::CMD_ORDER)) order_rev <= link.cmd_data[0];
      if (is_cmd(link.cmd_code, lcdrv_pkg::CMD_RMW_ON)) rmw_on <= 1'b1;
      if (is_cmd(link.cmd_code, lcdrv_pkg::CMD_RMW_OFF)) rmw_on <= 1'b0;
      if (is_cmd(link.cmd_code, lcdrv_pkg::CMD_BIAS)) bias_sel <= link.cmd_data[0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (pin_rst) begin
      {booster_en, regulator_en, follower_en} <= lcdrv_pkg::PWR_RST;
    end else if (wr_ok && is_cmd(link.cmd_code, lcdrv_pkg::CMD_POWER)) begin
      booster_en <= link.cmd_data[lcdrv_pkg::PWR_BOOST_BIT];
      regulator_en <= link.cmd_data[lcdrv_pkg::PWR_REG_BIT];
      follower_en <= link.cmd_data[lcdrv_pkg::PWR_FOLLOW_BIT];
    end
  end

  // Items shared by pin reset and the reset command
  wire any_rst = pin_rst | soft_rst;
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      static_on <= 1'b0;
      start_line <= lcdrv_pkg::START_LINE_RST;
      column <= lcdrv_pkg::COL_RST;
      page <= lcdrv_pkg::PAGE_RST;
      out_stat_d3 <= 1'b0;
      volume <= lcdrv_pkg::VOL_RST;
      test_on <= 1'b0;
    end else if (wr_ok) begin
      if (is_cmd(link.cmd_code, lcdrv_pkg::CMD_STATIC)) static_on <= link.cmd_data[0];
      if (is_cmd(link.cmd_code, lcdrv_pkg::CMD_START)) start_line <= link.cmd_data[5:0];
      if (is_cmd(link.cmd_code, lcdrv_pkg::CMD_COL)) column <= link.cmd_data;
      if (is_cmd(link.cmd_code, lcdrv_pkg::CMD_PAGE)) page <= link.cmd_data[3:0];
      if (is_cmd(link.cmd_code, lcdrv_pkg::CMD_OUTSTAT)) out_stat_d3 <= link.cmd_data[3];
      if (is_cmd(link.cmd_code, lcdrv_pkg::CMD_VOLUME)) volume <= link.cmd_data[4:0];
      if (is_cmd(link.cmd_code, lcdrv_pkg::CMD_TEST)) test_on <= link.cmd_data[0];
    end
  end

  // Serial input shift register; a partial byte is dropped by the pin
  logic [lcdrv_pkg::SER_CNT_W-1:0] ser_cnt_r;
  logic [lcdrv_pkg::SER_W-1:0] ser_sh_r;
  always_ff @(posedge ref_clk) begin
    if (pin_rst) begin
      ser_cnt_r <= '0;
      ser_sh_r <= '0;
      ser_word <= '0;
      ser_word_valid <= 1'b0;
    end else begin
      ser_word_valid <= 1'b0;
      if (sclk_rise) begin
        ser_sh_r <= {ser_sh_r[6:0], sdat_sync_r[2]};
        ser_cnt_r <= ser_cnt_r + 1'b1;
        if (ser_cnt_r == 3'h7) begin
          ser_word <= {ser_sh_r[6:0], sdat_sync_r[2]};
          ser_word_valid <= 1'b1;
        end
      end
    end
  end

  // Status byte, registered
  wire in_reset = (state_r != LCDRV_ST_IDLE);
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      link.status <= lcdrv_pkg::STAT_RST;
    end else begin
      link.status <= {in_reset, order_rev, ~display_on, in_reset, 4'h0};
    end
  end

  // Timing outputs run from sys_rst only, never from the pin reset
  logic [3:0] tdiv_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tdiv_r <= 4'h0;
      display_clock_out <= 1'b0;
      frame_alternation <= 1'b0;
      common_start_pulse <= 1'b0;
    end else begin
      tdiv_r <= tdiv_r + 1'b1;
      display_clock_out <= tdiv_r[1];
      if (tdiv_r == 4'hf) frame_alternation <= ~frame_alternation;
      common_start_pulse <= (tdiv_r == 4'hf);
    end
  end
endmodule : lcdrv_dev

// [core/lcdrv_pkg.sv]
// Shared constants for the display driver reset, init and contrast logic
package lcdrv_pkg;
  localparam int VOL_W = 5;
  localparam logic [4:0] VOL_RST = 5'h00;
  localparam logic [4:0] VOL_MID_HI = 5'h10;
  localparam logic [4:0] VOL_MID_LO = 5'h0f;
  localparam int PWR_W = 3;
  localparam logic [2:0] PWR_RST = 3'h0;
  localparam int PWR_BOOST_BIT = 2;
  localparam int PWR_REG_BIT = 1;
  localparam int PWR_FOLLOW_BIT = 0;
  localparam logic [2:0] PWR_ALL_ON = 3'h7;
  localparam logic [2:0] PWR_REG_FOLLOW = 3'h3;
  localparam logic [5:0] START_LINE_RST = 6'h01;
  localparam logic [7:0] COL_RST = 8'h00;
  localparam logic [3:0] PAGE_RST = 4'h0;
  // Bias code 0 is the variant's default ratio: 1/6 on the small variant, 1/8 on the larger ones
  localparam logic BIAS_RST_SMALL = 1'b0;
  localparam logic BIAS_RST_LARGE = 1'b0;
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_ORDER_BIT = 6;
  localparam int STAT_OFF_BIT = 5;
  localparam int STAT_RESET_BIT = 4;
  // Busy, display off and reset all set while sys_rst holds the driver
  localparam logic [7:0] STAT_RST = 8'hb0;
  localparam int SER_W = 8;
  localparam int SER_CNT_W = 3;
  // Reset busy time in ns and its cycle count at 250 MHz (4 ns)
  localparam int CLK_PERIOD_NS = 4;
  localparam int INIT_BUSY_NS = 40;
  localparam int INIT_BUSY_CYC = (INIT_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_CNT_W = 4;
  // Host sequencing: power-up reset hold time and its cycle count
  localparam int HOST_RST_NS = 80;
  localparam int HOST_RST_CYC = (HOST_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_CNT_W = 6;
  // Command codes carried on the link
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_DISP = 4'h1;
  localparam logic [3:0] CMD_INVERT = 4'h2;
  localparam logic [3:0] CMD_ORDER = 4'h3;
  localparam logic [3:0] CMD_RMW_ON = 4'h4;
  localparam logic [3:0] CMD_RMW_OFF = 4'h5;
  localparam logic [3:0] CMD_POWER = 4'h6;
  localparam logic [3:0] CMD_BIAS = 4'h7;
  localparam logic [3:0] CMD_STATIC = 4'h8;
  localparam logic [3:0] CMD_START = 4'h9;
  localparam logic [3:0] CMD_COL = 4'ha;
  localparam logic [3:0] CMD_PAGE = 4'hb;
  localparam logic [3:0] CMD_OUTSTAT = 4'hc;
  localparam logic [3:0] CMD_VOLUME = 4'hd;
  localparam logic [3:0] CMD_TEST = 4'he;
  localparam logic [3:0] CMD_SOFT_RST = 4'hf;
endpackage : lcdrv_pkg

// [core/lcdrv_if.sv]
// Link between host controller and display driver: reset pin, command strobe, serial input, status
`timescale 1ns/10ps
interface lcdrv_if;
  logic init_pin_n;
  logic cmd_valid;
  logic [3:0] cmd_code;
  logic [7:0] cmd_data;
  logic ser_clk;
  logic ser_data;
  logic [7:0] status;
  modport dev (
    input init_pin_n,
    input cmd_valid,
    input cmd_code,
    input cmd_data,
    input ser_clk,
    input ser_data,
    output status
  );
  modport host (
    output init_pin_n,
    output cmd_valid,
    output cmd_code,
    output cmd_data,
    output ser_clk,
    output ser_data,
    input status
  );
endinterface : lcdrv_if

// [core/lcdrv_host.sv]
// Host end: power-up pin reset, command issue with busy wait, serial byte send, power sequencing
`timescale 1ns/10ps
module lcdrv_host (
  input wire logic ref_clk,
  input wire logic sys_rst,
  lcdrv_if.host link,
  input wire logic req_valid,
  input wire logic [3:0] req_code,
  input wire logic [7:0] req_data,
  output logic req_ready,
  input wire logic ser_valid,
  input wire logic [7:0] ser_byte,
  output logic ser_ready,
  output logic [7:0] status_seen,
  output logic init_done
);
  typedef enum logic [1:0] {
    LCDRV_H_RST = 2'b00,
    LCDRV_H_WAIT = 2'b01,
    LCDRV_H_READY = 2'b10
  } lcdrv_hstate_t;

  lcdrv_hstate_t st_r;
  logic [lcdrv_pkg::HOST_CNT_W-1:0] cnt_r;
  logic standby_r;
  logic sr_wait_r;
  logic [2:0] st_sync_r;
  logic busy_lvl_r;

  // Busy bit crosses in via three flops
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_sync_r <= 3'h7;
      busy_lvl_r <= 1'b1;
      status_seen <= 8'h00;
    end else begin
      st_sync_r <= {st_sync_r[1:0], link.status[lcdrv_pkg::STAT_BUSY_BIT]};
      if (st_sync_r[1] == st_sync_r[2]) busy_lvl_r <= st_sync_r[2];
      status_seen <= link.status;
    end
  end

  // Pin reset at every power-up, held while supplies come on
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= LCDRV_H_RST;
      cnt_r <= '0;
      link.init_pin_n <= 1'b0;
      init_done <= 1'b0;
    end else begin
      case (st_r)
        LCDRV_H_RST: begin
          if (cnt_r == lcdrv_pkg::HOST_CNT_W'(lcdrv_pkg::HOST_RST_CYC - 1)) begin
            link.init_pin_n <= 1'b1;
            st_r <= LCDRV_H_WAIT;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        LCDRV_H_WAIT: begin
          if (!busy_lvl_r && !link.cmd_valid) begin
            st_r <= LCDRV_H_READY;
            init_done <= 1'b1;
          end
        end
        LCDRV_H_READY: st_r <= LCDRV_H_READY;
        default: st_r <= LCDRV_H_RST;
      endcase
    end
  end

  // Power-off only after standby; nonzero volume only with regulator and follower on
  logic [2:0] pwr_r;
  wire is_pwr = (req_code == lcdrv_pkg::CMD_POWER);
  wire pwr_ok = !is_pwr || req_data[2:0] != lcdrv_pkg::PWR_RST || standby_r;
  wire vol_ok = (req_code != lcdrv_pkg::CMD_VOLUME) || req_data[4:0] == lcdrv_pkg::VOL_RST
                || (pwr_r & lcdrv_pkg::PWR_REG_FOLLOW) == lcdrv_pkg::PWR_REG_FOLLOW;
  // Busy reaches us late through the status register and the synchroniser, so after a reset
  // command no further command goes out until busy has been seen rising and then falling again
  wire can_issue = (st_r == LCDRV_H_READY) && !busy_lvl_r && !link.cmd_valid && !sr_wait_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      link.cmd_valid <= 1'b0;
      link.cmd_code <= lcdrv_pkg::CMD_NOP;
      link.cmd_data <= 8'h00;
      req_ready <= 1'b0;
      pwr_r <= lcdrv_pkg::PWR_RST;
      // The power-up pin reset leaves the display off, which is standby
      standby_r <= 1'b1;
      sr_wait_r <= 1'b0;
    end else begin
      link.cmd_valid <= 1'b0;
      req_ready <= 1'b0;
      if (busy_lvl_r) sr_wait_r <= 1'b0;
      if (can_issue && req_valid && pwr_ok && vol_ok && !req_ready) begin
        link.cmd_valid <= 1'b1;
        link.cmd_code <= req_code;
        link.cmd_data <= req_data;
        req_ready <= 1'b1;
        if (is_pwr) pwr_r <= req_data[2:0];
        if (req_code == lcdrv_pkg::CMD_DISP) standby_r <= ~req_data[0];
        if (req_code == lcdrv_pkg::CMD_SOFT_RST) sr_wait_r <= 1'b1;
      end
    end
  end

  // Serial byte, MSB first, clock at ref_clk/4
  logic [3:0] bit_r;
  logic [1:0] sdiv_r;
  logic [7:0] sh_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bit_r <= 4'h0;
      sdiv_r <= 2'h0;
      sh_r <= 8'h00;
      link.ser_clk <= 1'b0;
      link.ser_data <= 1'b0;
      ser_ready <= 1'b0;
    end else begin
      ser_ready <= 1'b0;
      if (bit_r == 4'h0) begin
        if (ser_valid && init_done && !ser_ready) begin
          sh_r <= ser_byte;
          bit_r <= 4'h8;
          sdiv_r <= 2'h0;
          ser_ready <= 1'b1;
        end
      end else begin
        sdiv_r <= sdiv_r + 1'b1;
        if (sdiv_r == 2'h0) begin
          link.ser_data <= sh_r[7];
          link.ser_clk <= 1'b0;
        end else if (sdiv_r == 2'h2) begin
          link.ser_clk <= 1'b1;
        end else if (sdiv_r == 2'h3) begin
          sh_r <= {sh_r[6:0], 1'b0};
          bit_r <= bit_r - 1'b1;
        end
      end
    end
  end
endmodule : lcdrv_host

// [tb/lcdrv_properties.sv]
// Concurrent checks on the host-to-driver link and the driver's register outputs
`timescale 1ns/10ps
module lcdrv_properties (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic init_pin_n,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [7:0] cmd_data,
  input wire logic [7:0] status,
  input wire logic display_on,
  input wire logic booster_en,
  input wire logic regulator_en,
  input wire logic follower_en,
  input wire logic static_on,
  input wire logic [5:0] start_line,
  input wire logic [7:0] column,
  input wire logic [3:0] page,
  input wire logic [4:0] volume
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // Six low samples outlast the pin filter but not the late status register, which needs seven; busy is bit 7, reset bit 4
  sequence s_pin_held;
    !init_pin_n [*6];
  endsequence
  sequence s_take(logic [3:0] code);
    cmd_valid && cmd_code == code && !status[7];
  endsequence
  property p_pin_busy;
    s_pin_held |-> status[7] && status[4];
  endproperty
  a_pin_busy: assert property (p_pin_busy) else $error("busy or reset flag low while pin held");
  property p_pin_power;
    s_pin_held |-> !booster_en && !regulator_en && !follower_en;
  endproperty
  a_pin_power: assert property (p_pin_power) else $error("power bits set while pin held");
  property p_pin_regs;
    s_pin_held |-> !static_on && start_line == 6'h01 && column == 8'h00 && page == 4'h0 && volume == 5'h00;
  endproperty
  a_pin_regs: assert property (p_pin_regs) else $error("register off its initial value while pin held");
  property p_busy_after;
    $rose(init_pin_n) |-> status[7] [*8];
  endproperty
  a_busy_after: assert property (p_busy_after) else $error("busy dropped too soon after pin release");
  property p_busy_ends;
    $rose(init_pin_n) |-> ##[8:30] !status[7];
  endproperty
  a_busy_ends: assert property (p_busy_ends) else $error("busy never dropped after pin release");
  property p_vol_load;
    s_take(4'hd) |-> ##1 volume == cmd_data[4:0];
  endproperty
  a_vol_load: assert property (p_vol_load) else $error("volume not loaded by its command");
  property p_pwr_load;
    s_take(4'h6) |-> ##1 {booster_en, regulator_en, follower_en} == cmd_data[2:0];
  endproperty
  a_pwr_load: assert property (p_pwr_load) else $error("power bits not loaded by their command");
  property p_soft;
    s_take(4'hf) |-> ##1 (volume == 5'h00 && start_line == 6'h01 && column == 8'h00 && page == 4'h0 && !static_on
      && $stable({booster_en, regulator_en, follower_en, display_on}));
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset wrong");
  property p_host_pwr_off;
    cmd_valid && cmd_code == 4'h6 && cmd_data[2:0] == 3'h0 |-> !display_on;
  endproperty
  a_host_pwr_off: assert property (p_host_pwr_off) else $error("power off sent with display on");
  property p_host_vol;
    cmd_valid && cmd_code == 4'hd && cmd_data[4:0] != 5'h00 |-> regulator_en && follower_en;
  endproperty
  a_host_vol: assert property (p_host_vol) else $error("volume sent without regulator and follower");
  property p_host_pin;
    $fell(sys_rst) |-> ##1 !init_pin_n [*8];
  endproperty
  a_host_pin: assert property (p_host_pin) else $error("no pin reset at power up");
endmodule : lcdrv_properties

// [tb/lcd_reset_and_volume_init_bench.sv]
// Bench: host and driver joined by one link, a second driver on a hand-driven link
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module lcd_reset_and_volume_init_bench;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic [3:0] req_code = 4'h0;
  logic [7:0] req_data = 8'h00;
  logic ser_valid = 1'b0;
  logic [7:0] ser_byte = 8'h00;
  logic ser_ready;
  logic [7:0] status_seen;
  logic req_ready, init_done, display_on, invert, order_rev, rmw_on, booster_en, regulator_en, follower_en;
  logic bias_sel, static_on, out_stat_d3, test_on, dclk2;
  logic [5:0] start_line;
  logic [7:0] column, ser_word2, ser_word1;
  logic [3:0] page;
  logic [4:0] volume, vol2;
  logic [33:0] state, m;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  integer seed = 32'h9281;
  // Command code in the top nibble, argument below; mid-scale volume before tuning
  logic [11:0] corner [14] = '{12'h607, 12'h604, 12'h602, 12'h601, 12'hd10, 12'h603, 12'hd10, 12'hd0f, 12'hd1f,
    12'hf00, 12'h101, 12'h600, 12'h100, 12'h600};
  assign state = {display_on, invert, order_rev, rmw_on, booster_en, regulator_en, follower_en, bias_sel, static_on,
    start_line, column, page, out_stat_d3, volume, test_on};
  always #2 ref_clk = ~ref_clk;
  lcdrv_if link ();
  lcdrv_if link2 ();
  lcdrv_host u_lcdrv_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link), .req_valid(req_valid),
    .req_code(req_code), .req_data(req_data), .req_ready(req_ready), .ser_valid(ser_valid), .ser_byte(ser_byte),
    .ser_ready(ser_ready), .status_seen(status_seen), .init_done(init_done));
  lcdrv_dev u_lcdrv_dev (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link), .display_on(display_on),
    .invert(invert), .order_rev(order_rev), .rmw_on(rmw_on), .booster_en(booster_en), .regulator_en(regulator_en),
    .follower_en(follower_en), .bias_sel(bias_sel), .static_on(static_on), .start_line(start_line), .column(column),
    .page(page), .out_stat_d3(out_stat_d3), .volume(volume), .test_on(test_on), .ser_word(ser_word1),
    .ser_word_valid(),
    .frame_alternation(), .display_clock_out(), .common_start_pulse());
  lcdrv_dev u_lcdrv_dev_2 (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link2), .display_on(), .invert(),
    .order_rev(), .rmw_on(), .booster_en(), .regulator_en(), .follower_en(), .bias_sel(), .static_on(),
    .start_line(), .column(), .page(), .out_stat_d3(), .volume(vol2), .test_on(), .ser_word(ser_word2),
    .ser_word_valid(), .frame_alternation(), .display_clock_out(dclk2), .common_start_pulse());
  lcdrv_properties u_lcdrv_properties (.ref_clk(ref_clk), .sys_rst(sys_rst), .init_pin_n(link.init_pin_n),
    .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code), .cmd_data(link.cmd_data), .status(link.status),
    .display_on(display_on), .booster_en(booster_en), .regulator_en(regulator_en), .follower_en(follower_en),
    .static_on(static_on), .start_line(start_line), .column(column), .page(page), .volume(volume));
  function automatic logic [33:0] exp_init(input logic [7:0] kept);
    return {kept, 1'b0, lcdrv_pkg::START_LINE_RST, lcdrv_pkg::COL_RST, lcdrv_pkg::PAGE_RST, 1'b0,
      lcdrv_pkg::VOL_RST, 1'b0};
  endfunction : exp_init
  // Mirrors the host's refusals too, so refused requests leave the model alone
  function automatic logic [33:0] apply(input logic [33:0] q, input logic [3:0] c, input logic [7:0] d);
    logic [33:0] r;
    r = q;
    case (c)
      4'h1: r[33] = d[0];
      4'h2: r[32] = d[0];
      4'h3: r[31] = d[0];
      4'h4: r[30] = 1'b1;
      4'h5: r[30] = 1'b0;
      4'h6: if (d[2:0] != 3'h0 || !q[33]) r[29:27] = d[2:0];
      4'h7: r[26] = d[0];
      4'h8: r[25] = d[0];
      4'h9: r[24:19] = d[5:0];
      4'ha: r[18:11] = d;
      4'hb: r[10:7] = d[3:0];
      4'hc: r[6] = d[3];
      4'hd: if (d[4:0] == 5'h00 || (q[28] && q[27])) r[5:1] = d[4:0];
      4'he: r[0] = d[0];
      4'hf: r = exp_init(q[33:26]);
      default: r = q;
    endcase
    return r;
  endfunction : apply
  task automatic test_done;
    if (num_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic req(input logic [3:0] c, input logic [7:0] d);
    int n;
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_code = c;
    req_data = d;
    for (n = 0; n < 40 && req_ready !== 1'b1; n++) @(negedge ref_clk);
    req_valid = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask : req
  task automatic cmd2(input logic [3:0] c, input logic [7:0] d);
    @(negedge ref_clk);
    link2.cmd_valid = 1'b1;
    link2.cmd_code = c;
    link2.cmd_data = d;
    @(negedge ref_clk);
    link2.cmd_valid = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask : cmd2
  // Serial clock stands low between bits; the idle data line shows the inverse of the last bit
  task automatic sbit(input logic b);
    link2.ser_data = b;
    repeat (2) @(negedge ref_clk);
    link2.ser_clk = 1'b1;
    repeat (2) @(negedge ref_clk);
    link2.ser_clk = 1'b0;
    link2.ser_data = ~b;
    @(negedge ref_clk);
  endtask : sbit
  task automatic wait2;
    int n;
    for (n = 0; n < 60 && link2.status[7] !== 1'b0; n++) @(negedge ref_clk);
    `CHK(link2.status[7], 1'b0)
  endtask : wait2
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    int i;
    int flips;
    logic [11:0] op;
    logic last;
    {link2.init_pin_n, link2.cmd_valid, link2.cmd_code, link2.cmd_data, link2.ser_clk, link2.ser_data} = '0;
    m = exp_init({7'h00, lcdrv_pkg::BIAS_RST_SMALL});
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    for (i = 0; i < 200 && init_done !== 1'b1; i++) @(negedge ref_clk);
    `CHK(init_done, 1'b1)
    `CHK(state, m)
    `CHK(status_seen, 8'h20)
    for (i = 0; i < 70; i++) begin
      op = (i < 14) ? corner[i] : 12'($random(seed));
      req(op[11:8], op[7:0]);
      m = apply(m, op[11:8], op[7:0]);
      `CHK(state, m)
    end
    @(negedge ref_clk);
    ser_valid = 1'b1;
    ser_byte = 8'($random(seed));
    for (i = 0; i < 20 && ser_ready !== 1'b1; i++) @(negedge ref_clk);
    ser_valid = 1'b0;
    repeat (48) @(negedge ref_clk);
    `CHK(ser_word1, ser_byte)
    link2.init_pin_n = 1'b1;
    wait2();
    cmd2(4'hd, 8'h15);
    `CHK(vol2, 5'h15)
    sbit(1'b1);
    sbit(1'b0);
    sbit(1'b1);
    link2.init_pin_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    cmd2(4'hd, 8'h0a);
    `CHK({link2.status[7], link2.status[4]}, 2'b11)
    `CHK(vol2, 5'h00)
    flips = 0;
    last = dclk2;
    for (i = 0; i < 100; i++) begin
      @(negedge ref_clk);
      flips += (dclk2 !== last);
      last = dclk2;
    end
    `CHK(flips != 0, 1'b1)
    link2.init_pin_n = 1'b1;
    wait2();
    `CHK(vol2, 5'h00)
    for (i = 7; i >= 0; i--) sbit(8'ha5 >> i);
    repeat (4) @(negedge ref_clk);
    `CHK(ser_word2, 8'ha5)
    test_done();
  end
endmodule : lcd_reset_and_volume_init_bench
